// >>> rtl/ustc_regs.svh
// Register offsets, field positions and constants of the serial timing block
// Function
// - Zero time-out value disables receiver time-out
// - Time-out delay equals value times bit period
// - Write protect blocks protected configuration writes
// - Zero guard value inserts no guard time
// - Guard holds line idle value bit periods
// - Zero card ratio stops card bit clock
// - Card bit rate is card clock over ratio
// - Count card errors, clear count on read
// - Filter field sets infrared demodulator filter
// - Drift compensation resynchronises, needs 16x clock
// - Polarity bit chooses Manchester transition sense
// - Preamble code selects ones, zeros, alternating
// - Receive preamble length zero disables detection
// - Transmit preamble sent for length bit periods
// - LIN slave synchronises unless sync disabled
// - DMA may load frame config except itself
// - Response length is length code plus one
// - Length source one uses identifier bits five:four
// - Wakeup style selects LIN 2.0 or 1.3
// - Frame slot timing unless slot disable set
// - Checksum style zero enhanced, one classic
// - Checksum and parity generated, checked, or removed
// - Node action selects publish, subscribe, ignore
// - Mode codes select LIN master or slave
// - Write protect bit changes only with key
`ifndef USTC_REGS_SVH
`define USTC_REGS_SVH
`define USTC_OFF_RTO   8'h24
`define USTC_OFF_TTG   8'h28
`define USTC_OFF_CDIV  8'h40
`define USTC_OFF_NERR  8'h44
`define USTC_OFF_IRF   8'h4c
`define USTC_OFF_MAN   8'h50
`define USTC_OFF_LIN   8'h54
`define USTC_OFF_WPM   8'he4
`define USTC_RST_CDIV  11'h174
`define USTC_RST_MAN   32'h30011004
`define USTC_MAN_MASK  32'h530f130f
`define USTC_MAN_FIX   32'h20000000
`define USTC_WP_KEY    24'h555341
`define USTC_MODE_MST  4'ha
`define USTC_MODE_SLV  4'hb
`define USTC_MAN_DRIFT 30
`define USTC_MAN_RPOL  28
`define USTC_MAN_TPOL  12
`define USTC_LIN_SYNCD 17
`define USTC_LIN_DMAL  16
`define USTC_LIN_WKUP  7
`define USTC_LIN_SLOTD 6
`define USTC_LIN_LSRC  5
`define USTC_LIN_CHKT  4
`define USTC_LIN_CHKD  3
`define USTC_LIN_PARD  2
`define USTC_RESP_OK   2'h0
`define USTC_RESP_ERR  2'h2
`endif

// >>> rtl/ustc_pkg.sv
// Types shared by the serial timing and coding configuration block
`default_nettype none
package ustc_pkg;
  typedef struct packed {
    logic [16:0] to_val;
    logic [7:0]  gt;
    logic [10:0] ratio;
    logic [7:0]  nerr;
    logic [7:0]  irf;
    logic [31:0] manchester_config;
    logic [17:0] lin;
    logic        wplk;
    logic [16:0] to_cnt;
    logic        to_evt;
    logic [7:0]  gt_cnt;
    logic [10:0] cd_cnt;
    logic        card_tick;
    logic [3:0]  tpre_cnt;
    logic [3:0]  tpre_idx;
    logic [3:0]  rpre_cnt;
    logic        rpre_det;
    logic        tx_half;
    logic        rx_bit;
    logic        wk20;
    logic        wk13;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ustc_state_t;
endpackage : ustc_pkg
`default_nettype wire

// >>> rtl/ustc_config.sv
// Serial timing, line coding and LIN frame configuration with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ustc_regs.svh"
module ustc_config (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  op_mode,
  input  wire logic        card_mode,
  input  wire logic        oversample_16x,
  input  wire logic        bit_tick,
  input  wire logic        card_clk_tick,
  input  wire logic        card_error,
  input  wire logic        start_timeout,
  input  wire logic        tx_char_done,
  input  wire logic        tx_preamble_start,
  input  wire logic        tx_data_bit,
  input  wire logic        rx_first_half,
  input  wire logic        rx_bit_valid,
  input  wire logic [7:0]  identifier_character,
  input  wire logic        send_wakeup_command,
  input  wire logic        dma_lin_valid,
  input  wire logic [17:0] dma_lin_data,
  output logic             rx_timeout,
  output logic             tx_guard_hold,
  output logic             card_bit_tick,
  output logic [7:0]       ir_filter,
  output logic             drift_active,
  output logic             tx_line_first_half,
  output logic             rx_decoded_bit,
  output logic             tx_preamble_active,
  output logic             rx_preamble_found,
  output logic             sync_enable,
  output logic [8:0]       response_length,
  output logic             wakeup_lin20,
  output logic             wakeup_lin13,
  output logic             frame_slot_enforce,
  output logic             checksum_enhanced,
  output logic             checksum_generate,
  output logic             checksum_check,
  output logic             parity_generate,
  output logic             parity_check,
  output logic [7:0]       id_with_parity,
  output logic             response_tx,
  output logic             response_rx
);

  // =====================================================================
  // Helpers
  // =====================================================================
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Preamble bit at position idx, in default polarity
  function automatic logic pre_bit(input logic [1:0] pp, input logic [3:0] idx);
    unique case (pp)
      2'h0: return 1'b1;
      2'h1: return 1'b0;
      2'h2: return idx[0];
      2'h3: return ~idx[0];
    endcase
  endfunction : pre_bit

  // LIN identifier parity bits P1:P0 over the six id bits
  function automatic logic [1:0] id_par(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
  endfunction : id_par

  ustc_pkg::ustc_state_t s_q;
  ustc_pkg::ustc_state_t s_d;

  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] wword;
  logic        tick;
  logic        lin_mst;
  logic        lin_slv;
  logic [1:0]  nsel;

  // =====================================================================
  // Bus handshake and decode
  // =====================================================================
  // Address and data taken together; one write answer outstanding at most
  assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
  assign s_axi_awready = s_axi_wvalid & ~s_q.bvalid;
  assign s_axi_wready  = s_axi_awvalid & ~s_q.bvalid;
  assign rd_fire       = s_axi_arvalid & ~s_q.rvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rdata   = s_q.rdata;
  assign wword         = s_axi_wdata;

  // Card divider drives bit timing in card mode, else the baud tick
  assign tick    = card_mode ? s_q.card_tick : bit_tick;
  assign lin_mst = (op_mode == `USTC_MODE_MST);
  assign lin_slv = (op_mode == `USTC_MODE_SLV);
  assign nsel    = s_q.lin[1:0];

  // =====================================================================
  // Next state
  // =====================================================================
  always_comb begin
    logic [31:0] rd;
    logic        ok;
    logic [31:0] nw;
    rd  = 32'h0;
    ok  = 1'b1;
    nw  = 32'h0;
    s_d = s_q;

    // Write side of the register file
    if (wr_fire) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `USTC_RESP_OK;
      unique case (s_axi_awaddr)
        `USTC_OFF_RTO: begin
          nw = merge({15'h0, s_q.to_val}, wword, s_axi_wstrb);
          if (!s_q.wplk) begin
            s_d.to_val = nw[16:0];
          end
        end
        `USTC_OFF_TTG: begin
          nw = merge({24'h0, s_q.gt}, wword, s_axi_wstrb);
          if (!s_q.wplk) begin
            s_d.gt = nw[7:0];
          end
        end
        `USTC_OFF_CDIV: begin
          nw = merge({21'h0, s_q.ratio}, wword, s_axi_wstrb);
          if (!s_q.wplk) begin
            s_d.ratio = nw[10:0];
          end
        end
        `USTC_OFF_IRF: begin
          nw = merge({24'h0, s_q.irf}, wword, s_axi_wstrb);
          if (!s_q.wplk) begin
            s_d.irf = nw[7:0];
          end
        end
        `USTC_OFF_MAN: begin
          nw = merge(s_q.manchester_config, wword, s_axi_wstrb);
          if (!s_q.wplk) begin
            s_d.manchester_config = nw & `USTC_MAN_MASK;
          end
        end
        `USTC_OFF_LIN: begin
          nw = merge({14'h0, s_q.lin}, wword, s_axi_wstrb);
          s_d.lin = nw[17:0];
        end
        `USTC_OFF_WPM: begin
          // Key must arrive whole; a partial strobe cannot carry it
          if (s_axi_wstrb == 4'hf && wword[31:8] == `USTC_WP_KEY) begin
            s_d.wplk = wword[0];
          end
        end
        `USTC_OFF_NERR: ok = 1'b1;
        default: ok = 1'b0;
      endcase
      if (!ok) begin
        s_d.bresp = `USTC_RESP_ERR;
      end
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // DMA loads frame config only while its own load bit is set
    if (dma_lin_valid && s_q.lin[`USTC_LIN_DMAL]
        && !(wr_fire && s_axi_awaddr == `USTC_OFF_LIN)) begin
      s_d.lin = {dma_lin_data[`USTC_LIN_SYNCD], 1'b1, dma_lin_data[15:0]};
    end

    // Card error total saturates; read clears, a new error still counts
    if (card_error && s_q.nerr != 8'hff) begin
      s_d.nerr = s_q.nerr + 8'h1;
    end
    if (rd_fire && s_axi_araddr == `USTC_OFF_NERR) begin
      s_d.nerr = {7'h0, card_error};
    end

    // Read side of the register file
    if (rd_fire) begin
      ok = 1'b1;
      unique case (s_axi_araddr)
        `USTC_OFF_RTO:  rd = {15'h0, s_q.to_val};
        `USTC_OFF_TTG:  rd = {24'h0, s_q.gt};
        `USTC_OFF_CDIV: rd = {21'h0, s_q.ratio};
        `USTC_OFF_NERR: rd = {24'h0, s_q.nerr};
        `USTC_OFF_IRF:  rd = {24'h0, s_q.irf};
        `USTC_OFF_MAN:  rd = s_q.manchester_config | `USTC_MAN_FIX;
        `USTC_OFF_LIN:  rd = {14'h0, s_q.lin};
        `USTC_OFF_WPM:  rd = {31'h0, s_q.wplk};
        default:        ok = 1'b0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = ok ? `USTC_RESP_OK : `USTC_RESP_ERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Receiver time-out: armed by start, counts bit periods down to zero
    s_d.to_evt = 1'b0;
    if (start_timeout) begin
      s_d.to_cnt = s_q.to_val;
    end else if (tick && s_q.to_cnt != 17'h0) begin
      s_d.to_cnt = s_q.to_cnt - 17'h1;
      s_d.to_evt = (s_q.to_cnt == 17'h1);
    end
    if (s_d.to_val == 17'h0) begin
      s_d.to_cnt = 17'h0;
      s_d.to_evt = 1'b0;
    end

    // Transmit guard: idle line for guard-value bit periods after each character
    if (tx_char_done) begin
      s_d.gt_cnt = s_q.gt;
    end else if (tick && s_q.gt_cnt != 8'h0) begin
      s_d.gt_cnt = s_q.gt_cnt - 8'h1;
    end

    // Card bit clock: card clock divided by ratio, silent at zero
    s_d.card_tick = 1'b0;
    if (!card_mode || s_q.ratio == 11'h0) begin
      s_d.cd_cnt = 11'h0;
    end else if (card_clk_tick) begin
      if (s_q.cd_cnt + 11'h1 >= s_q.ratio) begin
        s_d.cd_cnt    = 11'h0;
        s_d.card_tick = 1'b1;
      end else begin
        s_d.cd_cnt = s_q.cd_cnt + 11'h1;
      end
    end

    // Transmit preamble generator, one bit per bit period
    if (tx_preamble_start) begin
      s_d.tpre_cnt = s_q.manchester_config[3:0];
      s_d.tpre_idx = 4'h0;
    end else if (tick && s_q.tpre_cnt != 4'h0) begin
      s_d.tpre_cnt = s_q.tpre_cnt - 4'h1;
      s_d.tpre_idx = s_q.tpre_idx + 4'h1;
    end
    // Line coding: first half equals bit when polarity is zero
    s_d.tx_half = ((s_q.tpre_cnt != 4'h0) ? pre_bit(s_q.manchester_config[9:8], s_q.tpre_idx)
                  : tx_data_bit) ^ s_q.manchester_config[`USTC_MAN_TPOL];
    s_d.rx_bit  = rx_first_half ^ s_q.manchester_config[`USTC_MAN_RPOL];

    // Receive preamble detector: run of matching bits of set length
    s_d.rpre_det = 1'b0;
    if (s_q.manchester_config[19:16] == 4'h0) begin
      s_d.rpre_cnt = 4'h0;
    end else if (rx_bit_valid) begin
      if (s_q.rx_bit == pre_bit(s_q.manchester_config[25:24], s_q.rpre_cnt)) begin
        s_d.rpre_cnt = s_q.rpre_cnt + 4'h1;
        if (s_q.rpre_cnt + 4'h1 == s_q.manchester_config[19:16]) begin
          s_d.rpre_det = 1'b1;
          s_d.rpre_cnt = 4'h0;
        end
      end else begin
        s_d.rpre_cnt = 4'h0;
      end
    end

    // Wakeup request steered to the selected signal style
    s_d.wk20 = send_wakeup_command & ~s_q.lin[`USTC_LIN_WKUP];
    s_d.wk13 = send_wakeup_command & s_q.lin[`USTC_LIN_WKUP];
  end

  // =====================================================================
  // State register
  // =====================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.ratio <= `USTC_RST_CDIV;
      s_q.manchester_config   <= `USTC_RST_MAN & `USTC_MAN_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Configuration outputs
  // =====================================================================
  // Decoded controls for transmitter, receiver and frame handler
  assign rx_timeout         = s_q.to_evt;
  assign tx_guard_hold      = (s_q.gt_cnt != 8'h0);
  assign card_bit_tick      = s_q.card_tick;
  assign ir_filter          = s_q.irf;
  // Recovery only meaningful with 16x sampling; gated off unless oversample_16x is set
  assign drift_active       = s_q.manchester_config[`USTC_MAN_DRIFT] & oversample_16x;
  assign tx_line_first_half = s_q.tx_half;
  assign rx_decoded_bit     = s_q.rx_bit;
  assign tx_preamble_active = (s_q.tpre_cnt != 4'h0);
  assign rx_preamble_found  = s_q.rpre_det;
  assign sync_enable        = lin_slv & ~s_q.lin[`USTC_LIN_SYNCD];
  assign wakeup_lin20       = s_q.wk20;
  assign wakeup_lin13       = s_q.wk13;
  assign frame_slot_enforce = (lin_mst | lin_slv) & ~s_q.lin[`USTC_LIN_SLOTD];
  assign checksum_enhanced  = ~s_q.lin[`USTC_LIN_CHKT];
  assign checksum_generate  = lin_mst & ~s_q.lin[`USTC_LIN_CHKD];
  assign checksum_check     = lin_slv & ~s_q.lin[`USTC_LIN_CHKD];
  assign parity_generate    = lin_mst & ~s_q.lin[`USTC_LIN_PARD];
  assign parity_check       = (lin_mst | lin_slv) & ~s_q.lin[`USTC_LIN_PARD];
  assign id_with_parity     = {id_par(identifier_character[5:0]), identifier_character[5:0]};
  assign response_tx        = (nsel == 2'h0);
  assign response_rx        = (nsel == 2'h1);

  // Length from code plus one, or from identifier bits five and four
  always_comb begin
    if (!s_q.lin[`USTC_LIN_LSRC]) begin
      response_length = {1'b0, s_q.lin[15:8]} + 9'h1;
    end else begin
      unique case (identifier_character[5:4])
        2'h3:    response_length = 9'h8;
        2'h2:    response_length = 9'h4;
        default: response_length = 9'h2;
      endcase
    end
  end

  // =====================================================================
  // Checks
  // =====================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_timeout_off: assert property (s_q.to_val == 17'h0 |-> !rx_timeout)
    else $error("time-out reported while disabled");
  a_timeout_delay: assert property (rx_timeout |-> $past(s_q.to_cnt) == 17'h1)
    else $error("time-out not at end of count");
  a_protect_guard: assert property (s_q.wplk && wr_fire && s_axi_awaddr == `USTC_OFF_TTG
    |=> $stable(s_q.gt))
    else $error("protected guard register changed");
  a_guard_zero: assert property (tx_char_done && s_q.gt == 8'h0 |=> !tx_guard_hold)
    else $error("guard hold with zero guard");
  a_guard_load: assert property (tx_char_done && s_q.gt != 8'h0
    |=> tx_guard_hold && s_q.gt_cnt == $past(s_q.gt))
    else $error("guard not loaded");
  a_card_silent: assert property ($past(s_q.ratio) == 11'h0 |-> !card_bit_tick)
    else $error("card tick with zero ratio");
  a_nerr_clear: assert property (rd_fire && s_axi_araddr == `USTC_OFF_NERR && !card_error
    |=> s_q.nerr == 8'h0)
    else $error("error total not cleared by read");
  a_key_guard: assert property (wr_fire && s_axi_awaddr == `USTC_OFF_WPM
    && s_axi_wdata[31:8] != `USTC_WP_KEY |=> $stable(s_q.wplk))
    else $error("protect bit changed without key");
  a_dma_block: assert property (dma_lin_valid && !s_q.lin[`USTC_LIN_DMAL] && !wr_fire
    |=> $stable(s_q.lin))
    else $error("dma wrote frame config while not allowed");
  a_resp_len: assert property (!s_q.lin[`USTC_LIN_LSRC]
    |-> response_length == {1'b0, s_q.lin[15:8]} + 9'h1)
    else $error("response length wrong");
  a_wake_style: assert property (send_wakeup_command
    |=> wakeup_lin13 == $past(s_q.lin[`USTC_LIN_WKUP]) && wakeup_lin20 != wakeup_lin13)
    else $error("wrong wakeup style");

  c_timeout: cover property (start_timeout ##[1:40] rx_timeout);
  c_card_tick: cover property (card_mode && card_bit_tick);
  c_preamble: cover property (rx_preamble_found);
  c_dma_load: cover property (dma_lin_valid && s_q.lin[`USTC_LIN_DMAL]);

endmodule : ustc_config
`default_nettype wire

// >>> test/ustc_peer_model.sv
// Serial peer model: bit pacing, card clock and received half-bit levels
`timescale 1ns/1ps
`default_nettype none
module ustc_peer_model (
  input  wire logic aclk,
  input  wire logic run,
  output logic      bit_tick,
  output logic      card_clk_tick,
  output logic      rx_first_half,
  output logic      rx_bit_valid
);
  logic [1:0] div_q = 2'h0;
  logic       rx_q  = 1'h0;
  // ==========================================================
  // Pacing
  // One bit period every four cycles keeps time-out runs short
  always_ff @(posedge aclk) begin
    div_q         <= run ? div_q + 2'h1 : 2'h0;
    bit_tick      <= run && (div_q == 2'h3);
    card_clk_tick <= run;
    rx_bit_valid  <= run && (div_q == 2'h3);
  end
  // Idle line toggles each cycle so a stale level never looks valid
  always_ff @(posedge aclk) begin
    if (!run || div_q == 2'h3) begin
      rx_q <= ~rx_q;
    end
  end
  assign rx_first_half = rx_q;
endmodule : ustc_peer_model
`default_nettype wire

// >>> test/ustc_config_tb.sv
// Self-checking bench for the serial timing and LIN configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ustc_regs.svh"
module ustc_config_tb;
  logic        aclk = 1'h0, aresetn = 1'h0, run = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, id_chr = 8'h0, ir_f;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  op_mode = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        card_mode = 1'h0, os16 = 1'h0, card_err = 1'h0, start_to = 1'h0;
  logic        char_done = 1'h0, wake = 1'h0, dma_v = 1'h0, pre_go = 1'h0;
  logic [17:0] dma_d = 18'h0;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, bit_tick, cclk, rx_half, rx_bv;
  logic        rx_to, g_hold, c_tick, drift, w20, w13, pre_on;
  logic [8:0]  resp_len, flags;
  int          bad_count = 0, checks = 0, n_tick, n_to, n_hold, n_gh, n_card, to_at, n_w20, n_w13;
  always #25 aclk = ~aclk;
  // Pulse counters sampled mid-cycle, away from the launching edge
  always @(negedge aclk) begin
    n_tick += int'(bit_tick === 1'h1);
    n_to += int'(rx_to === 1'h1);
    if (rx_to === 1'h1) to_at = n_tick;
    n_hold += int'((g_hold | pre_on) === 1'h1 && bit_tick === 1'h1);
    n_gh += int'(g_hold === 1'h1);
    n_card += int'(c_tick === 1'h1);
    n_w20 += int'(w20 === 1'h1);
    n_w13 += int'(w13 === 1'h1);
  end
  ustc_config ustc_config_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op_mode(op_mode),
    .card_mode(card_mode), .oversample_16x(os16), .bit_tick(bit_tick),
    .card_clk_tick(cclk), .card_error(card_err), .start_timeout(start_to),
    .tx_char_done(char_done), .tx_preamble_start(pre_go), .tx_data_bit(1'h0),
    .rx_first_half(rx_half), .rx_bit_valid(rx_bv), .identifier_character(id_chr),
    .send_wakeup_command(wake), .dma_lin_valid(dma_v), .dma_lin_data(dma_d),
    .rx_timeout(rx_to), .tx_guard_hold(g_hold), .card_bit_tick(c_tick), .ir_filter(ir_f),
    .drift_active(drift), .tx_line_first_half(), .rx_decoded_bit(), .tx_preamble_active(pre_on),
    .rx_preamble_found(), .sync_enable(flags[3]), .response_length(resp_len),
    .wakeup_lin20(w20), .wakeup_lin13(w13), .frame_slot_enforce(flags[2]),
    .checksum_enhanced(flags[8]), .checksum_generate(flags[7]), .checksum_check(flags[6]),
    .parity_generate(flags[5]), .parity_check(flags[4]), .id_with_parity(),
    .response_tx(flags[1]), .response_rx(flags[0]));
  ustc_peer_model ustc_peer_model_i (.aclk(aclk), .run(run), .bit_tick(bit_tick),
    .card_clk_tick(cclk), .rx_first_half(rx_half), .rx_bit_valid(rx_bv));
  // ==========================================================
  // Shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait on one handshake; a hang ends the run
  task automatic wait_for(input int sel, input string nm);
    logic [3:0] hs;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      hs = {rvalid, arready, bvalid, awready};
      if (hs[sel] === 1'h1) return;
    end
    bad_count++;
    $display("[FAIL] %s expected 1 seen 0", nm);
    close_out();
  endtask : wait_for
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    wait_for(0, "write accept");
    @(posedge aclk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    wait_for(1, "write response");
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
    bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    wait_for(2, "read accept");
    @(posedge aclk);
    arvalid <= 1'h0;
    wait_for(3, "read data");
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask : rdr
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0]  a [6] = '{`USTC_OFF_RTO, `USTC_OFF_TTG, `USTC_OFF_CDIV, `USTC_OFF_IRF,
                           `USTC_OFF_MAN, `USTC_OFF_LIN};
    logic [31:0] e [6] = '{32'h0, 32'h0, 32'h174, 32'h0, 32'h30011004, 32'h0};
    for (int k = 0; k < 6; k++) begin
      rdr(a[k]);
      chk("reset value", e[k], rd);
    end
    rdr(8'h30);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    chk("unmapped rdata", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset
  // Expiry must land after exactly the programmed number of bit periods
  task automatic t_timeout(input logic [31:0] v);
    wr(`USTC_OFF_RTO, v, 2'h0);
    @(posedge aclk) start_to <= 1'h1;
    @(posedge aclk) start_to <= 1'h0;
    n_tick = 0;
    n_to = 0;
    @(posedge aclk) run <= 1'h1;
    repeat (40) @(posedge aclk);
    chk("timeout pulses", (v == 0) ? 32'h0 : 32'h1, 32'(n_to));
    if (v != 0) chk("ticks to timeout", v, 32'(to_at));
    @(posedge aclk) run <= 1'h0;
    $display("test timeout %0d done", v);
  endtask : t_timeout
  task automatic t_guard(input logic [31:0] v);
    wr(`USTC_OFF_TTG, v, 2'h0);
    @(posedge aclk) run <= 1'h1;
    n_hold = 0;
    n_gh = 0;
    @(posedge aclk) char_done <= 1'h1;
    @(posedge aclk) char_done <= 1'h0;
    repeat (30) @(posedge aclk);
    if (v == 0) chk("guard cycles", 32'h0, 32'(n_gh));
    else chk("guard bit periods", v, 32'(n_hold));
    @(posedge aclk) run <= 1'h0;
    $display("test guard %0d done", v);
  endtask : t_guard
  task automatic t_card();
    card_mode <= 1'h1;
    wr(`USTC_OFF_CDIV, 32'h3, 2'h0);
    @(posedge aclk) run <= 1'h1;
    repeat (4) @(posedge aclk);
    n_card = 0;
    repeat (30) @(posedge aclk);
    chk("card ticks ratio 3", 32'ha, 32'(n_card));
    wr(`USTC_OFF_CDIV, 32'h0, 2'h0);
    n_card = 0;
    repeat (30) @(posedge aclk);
    chk("card ticks ratio 0", 32'h0, 32'(n_card));
    repeat (3) begin
      @(posedge aclk) card_err <= 1'h1;
      @(posedge aclk) card_err <= 1'h0;
    end
    rdr(`USTC_OFF_NERR);
    chk("error total", 32'h3, rd);
    rdr(`USTC_OFF_NERR);
    chk("error total after read", 32'h0, rd);
    @(posedge aclk) run <= 1'h0;
    $display("test card done");
  endtask : t_card
  task automatic t_protect();
    wr(`USTC_OFF_WPM, {`USTC_WP_KEY, 8'h01}, 2'h0);
    rdr(`USTC_OFF_WPM);
    chk("protect readback", 32'h1, rd);
    wr(`USTC_OFF_TTG, 32'h5, 2'h0);
    rdr(`USTC_OFF_TTG);
    chk("guarded write", 32'h0, rd);
    wr(`USTC_OFF_WPM, 32'h12345600, 2'h0);
    rdr(`USTC_OFF_WPM);
    chk("bad key", 32'h1, rd);
    wr(`USTC_OFF_WPM, {`USTC_WP_KEY, 8'h00}, 2'h0);
    wr(`USTC_OFF_TTG, 32'h5, 2'h0);
    rdr(`USTC_OFF_TTG);
    chk("unguarded write", 32'h5, rd);
    wr(8'h30, 32'h1, 2'h2);
    $display("test protect done");
  endtask : t_protect
  task automatic t_man();
    wr(`USTC_OFF_MAN, 32'hffffffff, 2'h0);
    os16 <= 1'h1;
    rdr(`USTC_OFF_MAN);
    chk("coding fields", 32'h730f130f, rd);
    chk("drift active", 32'h1, {31'h0, drift});
    card_mode <= 1'h0;
    n_hold = 0;
    @(posedge aclk) pre_go <= 1'h1;
    @(posedge aclk) pre_go <= 1'h0;
    run <= 1'h1;
    repeat (70) @(posedge aclk);
    chk("preamble bit periods", 32'hf, 32'(n_hold));
    run <= 1'h0;
    wr(`USTC_OFF_IRF, 32'ha5, 2'h0);
    chk("ir filter", 32'ha5, {24'h0, ir_f});
    $display("test coding done");
  endtask : t_man
  task automatic t_lin();
    op_mode <= `USTC_MODE_MST;
    wr(`USTC_OFF_LIN, 32'hff00, 2'h0);
    chk("length code", 32'h100, {23'h0, resp_len});
    chk("master flags", 32'h1b6, {23'h0, flags});
    @(posedge aclk) wake <= 1'h1;
    @(posedge aclk) wake <= 1'h0;
    op_mode <= `USTC_MODE_SLV;
    id_chr <= 8'h30;
    wr(`USTC_OFF_LIN, 32'hfd, 2'h0);
    chk("length from identifier", 32'h8, {23'h0, resp_len});
    chk("slave flags", 32'h9, {23'h0, flags});
    @(posedge aclk) wake <= 1'h1;
    @(posedge aclk) wake <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("wakeup styles", 32'h10001, {n_w20[15:0], n_w13[15:0]});
    wr(`USTC_OFF_LIN, 32'h30000, 2'h0);
    chk("sync disabled", 32'h0, {31'h0, flags[3]});
    for (int k = 1; k >= 0; k--) begin
      wr(`USTC_OFF_LIN, {15'h0, k[0], 16'h0}, 2'h0);
      @(posedge aclk) dma_v <= 1'h1;
      dma_d <= 18'h0ff00;
      @(posedge aclk) dma_v <= 1'h0;
      rdr(`USTC_OFF_LIN);
      chk("dma load", k[0] ? 32'h1ff00 : 32'h0, rd);
    end
    $display("test frame config done");
  endtask : t_lin
  // ==========================================================
  // Main sequence
  initial begin
    n_w20 = 0;
    n_w13 = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_timeout(32'h2);
    t_timeout(32'h0);
    t_guard(32'h3);
    t_guard(32'h0);
    t_card();
    t_protect();
    t_man();
    t_lin();
    close_out();
  end
endmodule : ustc_config_tb
`default_nettype wire
